// File: core/pattern_word_pkg.sv
package pattern_word_pkg;
  // Bit positions within the pattern word
  localparam int unsigned LINE4_P1_BIT = 19;
  localparam int unsigned LINE5_P2_BIT = 20;
  localparam int unsigned LINE5_P1_BIT = 21;
  localparam int unsigned LOOP_BIT = 24;
  localparam int unsigned EXC_EN_BIT = 25;
  localparam int unsigned ADDR_SEL_FIRST_BIT = 26;
  localparam int unsigned ADDR_SEL_SECOND_BIT = 27;
  localparam int unsigned NEXT_INC_BIT = 28;
  localparam int unsigned ACK_VALUE_BIT = 29;
  localparam int unsigned TIMER_ON_BIT = 30;
  localparam int unsigned LAST_BIT = 31;

  localparam logic [5:0] EXC_START_ADDR = 6'h3c;

  // Address mux select codes
  localparam logic [1:0] ADDR_SRC_REQ = 2'h0;
  localparam logic [1:0] ADDR_SRC_MUXED = 2'h2;
  localparam logic [1:0] ADDR_SRC_HOLD_REG = 2'h3;

  // Port sizes and address steps
  localparam logic [1:0] PORT_32 = 2'h0;
  localparam logic [1:0] PORT_16 = 2'h1;
  localparam logic [3:0] STEP_32 = 4'h4;
  localparam logic [3:0] STEP_16 = 4'h2;
  localparam logic [3:0] STEP_8 = 4'h1;

  // Request kinds
  localparam logic [2:0] REQ_RD_SINGLE = 3'h0;
  localparam logic [2:0] REQ_RD_BURST = 3'h1;
  localparam logic [2:0] REQ_WR_SINGLE = 3'h2;
  localparam logic [2:0] REQ_WR_BURST = 3'h3;
  localparam logic [2:0] REQ_TIMER = 3'h4;

  // Multiplexed address shift base
  localparam int unsigned MUX_SHIFT_BASE = 8;

  // Bank disable timer
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned DISABLE_TIME_NS = 200;
  localparam int unsigned DISABLE_CYCLES =
    (DISABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PH1 = 3'b010,
    ST_PH2 = 3'b100
  } seq_state_t;
endpackage : pattern_word_pkg

// File: core/memory_pattern_word_decoder.sv
`timescale 1ns/100ps
// Overview of operation
// [RQ1] Bit 19 drives line four at phase-one end
// [RQ2] Disabled line four: bit 19 freezes on wait
// [RQ3] Bit 20 drives line five at phase-two end
// [RQ4] Bit 21 drives line five at phase-one end
// [RQ5] Bit 24 marks loop start, then end
// [RQ6] Loop body repeats loop-count times
// [RQ7] Bit 25 enables exception branch on error/reset
// [RQ8] Exception branch fetches from 0x3c onward
// [RQ9] Bits 26-27 select driven address source
// [RQ10] Bit 28 steps address by port size
// [RQ11] Bit 28 clear: address not stepped
// [RQ12] Address step only for burst requests
// [RQ13] Bit 29 drives transfer acknowledge at phase two
// [RQ14] Bit 30 starts bank disable timer
// [RQ15] Bit 31 ends service of the request
// [RQ16] Words run sequentially from start location
// [RQ17] Loop count loaded per request; last resets loop
module memory_pattern_word_decoder #(
  parameter int unsigned BANK_BITS = 3,
  parameter int unsigned LOOP_BITS = 4,
  parameter int unsigned DISABLE_CYCLES = pattern_word_pkg::DISABLE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Service request, held until acknowledged
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic [5:0] req_start,
  input wire logic [31:0] req_addr,
  input wire logic [BANK_BITS-1:0] req_bank,
  input wire logic [1:0] port_size,
  output logic req_ack_q,
  output logic busy_q,
  output logic service_done_q,
  // Machine mode settings
  input wire logic general_line_four_disable,
  input wire logic [LOOP_BITS-1:0] read_loop_count,
  input wire logic [LOOP_BITS-1:0] write_loop_count,
  input wire logic [LOOP_BITS-1:0] timer_loop_count,
  input wire logic [2:0] address_multiplex_scheme,
  input wire logic [31:0] memory_address_holding_reg,
  // Pattern store
  output logic [5:0] word_addr_q,
  input wire logic [12:0] word_upper,
  // External pins
  input wire logic wait_n,
  input wire logic transfer_error_ack_n,
  input wire logic reset_request,
  output logic internal_clock_phase_one_q,
  output logic internal_clock_phase_two_q,
  output logic general_line_four_q,
  output logic general_line_five_q,
  output logic [31:0] addr_q,
  output logic transfer_ack_n_q,
  output logic bank_disable_timer_on_q,
  output logic bank_blocked_q
);
  localparam int unsigned W0 = pattern_word_pkg::LINE4_P1_BIT;

  generate
    if (DISABLE_CYCLES < 1 || DISABLE_CYCLES > 65535 || LOOP_BITS < 1 || BANK_BITS < 1)
    begin : g_bad_param
      $error("memory_pattern_word_decoder: unsupported parameter value");
    end
  endgenerate

  function automatic logic [31:0] mux_address(input logic [31:0] a, input logic [2:0] s);
    mux_address = a >> (pattern_word_pkg::MUX_SHIFT_BASE + 32'(s));
  endfunction : mux_address

  function automatic logic wbit(input logic [12:0] w, input int unsigned pos);
    wbit = w[pos - W0];
  endfunction : wbit

  // Pin synchroniser: wait, error ack, reset request
  // A level counts only once stages two and three agree, so a pin caught
  // mid-change never reaches the sequencer as a one-cycle glitch
  logic [2:0] s1_q, s2_q, s3_q, pin_q, pin_d;
  always_comb begin
    pin_d = (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 3'h3;
      s2_q <= 3'h3;
      s3_q <= 3'h3;
      pin_q <= 3'h3;
    end else begin
      s1_q <= {~reset_request, transfer_error_ack_n, wait_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end
  logic wait_on, exc_seen;
  assign wait_on = ~pin_q[0];
  assign exc_seen = ~pin_q[1] | ~pin_q[2];

  // Sequencer state
  pattern_word_pkg::seq_state_t st_q, st_d;
  logic [12:0] word_q, word_d, cur_word;
  logic [5:0] waddr_d, loop_start_q, loop_start_d;
  logic [LOOP_BITS-1:0] loop_cnt_q, loop_cnt_d, loop_field_q, loop_field_d;
  logic in_loop_q, in_loop_d, burst_q, burst_d;
  logic [3:0] off_q, off_d, step_q, step_d;
  logic [31:0] base_q, base_d, addr_d;
  logic [BANK_BITS-1:0] bank_q, bank_d, tbank_q, tbank_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic ack_d, busy_d, done_d, ph1_d, ph2_d, l4_d, l5_d, ta_n_d, ton_d, blk_d;
  logic freeze, accept;

  assign cur_word = (st_q == pattern_word_pkg::ST_PH1) ? word_upper : word_q;

  always_comb begin
    st_d = st_q;
    word_d = word_q;
    waddr_d = word_addr_q;
    loop_start_d = loop_start_q;
    loop_cnt_d = loop_cnt_q;
    loop_field_d = loop_field_q;
    in_loop_d = in_loop_q;
    burst_d = burst_q;
    off_d = off_q;
    step_d = step_q;
    base_d = base_q;
    addr_d = addr_q;
    bank_d = bank_q;
    tbank_d = tbank_q;
    tcnt_d = (tcnt_q != 16'h0) ? tcnt_q - 16'h1 : 16'h0;
    ack_d = 1'b0;
    done_d = 1'b0;
    ton_d = 1'b0;
    l4_d = general_line_four_q;
    l5_d = general_line_five_q;
    ta_n_d = transfer_ack_n_q;
    // New access to a bank whose disable timer runs is held off
    accept = req_valid && !req_ack_q && st_q == pattern_word_pkg::ST_IDLE &&
             !(tcnt_q != 16'h0 && tbank_q == req_bank); // RQ14
    freeze = general_line_four_disable && wbit(cur_word, pattern_word_pkg::LINE4_P1_BIT)
             && wait_on; // RQ2
    case (st_q)
      pattern_word_pkg::ST_IDLE: begin
        if (accept) begin
          ack_d = 1'b1;
          st_d = pattern_word_pkg::ST_PH1;
          waddr_d = req_start; // RQ16
          base_d = req_addr;
          bank_d = req_bank;
          off_d = 4'h0;
          in_loop_d = 1'b0;
          burst_d = req_kind == pattern_word_pkg::REQ_RD_BURST ||
                    req_kind == pattern_word_pkg::REQ_WR_BURST;
          case (port_size)
            pattern_word_pkg::PORT_32: step_d = pattern_word_pkg::STEP_32;
            pattern_word_pkg::PORT_16: step_d = pattern_word_pkg::STEP_16;
            default: step_d = pattern_word_pkg::STEP_8;
          endcase
          // Loop count comes from the field that matches the request type
          case (req_kind) // RQ17
            pattern_word_pkg::REQ_RD_SINGLE, pattern_word_pkg::REQ_RD_BURST:
              loop_field_d = read_loop_count;
            pattern_word_pkg::REQ_WR_SINGLE, pattern_word_pkg::REQ_WR_BURST:
              loop_field_d = write_loop_count;
            default: loop_field_d = timer_loop_count;
          endcase
          loop_cnt_d = loop_field_d; // RQ17
        end
      end
      pattern_word_pkg::ST_PH1: begin
        // Trailing edge of phase one
        word_d = word_upper;
        st_d = pattern_word_pkg::ST_PH2;
        if (!general_line_four_disable) begin
          l4_d = wbit(word_upper, pattern_word_pkg::LINE4_P1_BIT); // RQ1
        end
        l5_d = wbit(word_upper, pattern_word_pkg::LINE5_P1_BIT); // RQ4
        // Bit 26 is the leading digit of the select code, bit 27 the trailing one
        case ({word_upper[pattern_word_pkg::ADDR_SEL_FIRST_BIT-W0],
               word_upper[pattern_word_pkg::ADDR_SEL_SECOND_BIT-W0]})
          pattern_word_pkg::ADDR_SRC_REQ: addr_d = {base_q[31:4], base_q[3:0] + off_q}; // RQ9
          pattern_word_pkg::ADDR_SRC_MUXED:
            addr_d = mux_address({base_q[31:4], base_q[3:0] + off_q},
                                 address_multiplex_scheme); // RQ9
          pattern_word_pkg::ADDR_SRC_HOLD_REG: addr_d = memory_address_holding_reg; // RQ9
          default: addr_d = addr_q;
        endcase
        // Step lands on the driven address; ignored outside bursts
        if (wbit(word_upper, pattern_word_pkg::NEXT_INC_BIT) && burst_q) begin // RQ12
          addr_d[3:0] = addr_d[3:0] + step_q; // RQ10
          off_d = off_q + step_q; // RQ10
        end // RQ11
        // Acknowledge leaves with the rise of phase two
        ta_n_d = wbit(word_upper, pattern_word_pkg::ACK_VALUE_BIT); // RQ13
      end
      pattern_word_pkg::ST_PH2: begin
        if (!freeze) begin // RQ2
          st_d = pattern_word_pkg::ST_PH1;
          ta_n_d = 1'b1;
          l5_d = wbit(word_q, pattern_word_pkg::LINE5_P2_BIT); // RQ3
          waddr_d = word_addr_q + 6'h1; // RQ16
          // One timer only: a start for another bank replaces the running one
          if (wbit(word_q, pattern_word_pkg::TIMER_ON_BIT)) begin
            ton_d = 1'b1;
            tbank_d = bank_q;
            tcnt_d = 16'(DISABLE_CYCLES); // RQ14
          end
          if (wbit(word_q, pattern_word_pkg::LOOP_BIT)) begin
            if (!in_loop_q) begin
              in_loop_d = 1'b1; // RQ5
              loop_start_d = word_addr_q;
              loop_cnt_d = loop_field_q;
            end else if (word_addr_q != loop_start_q) begin
              // Back at the start word after a jump is not a second boundary;
              // a count of 0 or 1 runs the body once and never wraps
              if (loop_cnt_q > LOOP_BITS'(1)) begin
                loop_cnt_d = loop_cnt_q - LOOP_BITS'(1); // RQ6
                waddr_d = loop_start_q; // RQ6
              end else begin
                loop_cnt_d = '0;
                in_loop_d = 1'b0; // RQ5
              end
            end
          end
          // Exception outranks a loop jump; the final word outranks both
          if (wbit(word_q, pattern_word_pkg::EXC_EN_BIT) && exc_seen) begin // RQ7
            waddr_d = pattern_word_pkg::EXC_START_ADDR; // RQ8
            in_loop_d = 1'b0;
          end
          if (wbit(word_q, pattern_word_pkg::LAST_BIT)) begin // RQ15
            st_d = pattern_word_pkg::ST_IDLE;
            done_d = 1'b1;
            in_loop_d = 1'b0; // RQ17
          end
        end
      end
      default: st_d = pattern_word_pkg::ST_IDLE;
    endcase
    busy_d = st_d != pattern_word_pkg::ST_IDLE;
    ph1_d = st_d == pattern_word_pkg::ST_PH1;
    ph2_d = st_d == pattern_word_pkg::ST_PH2;
    blk_d = tcnt_d != 16'h0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= pattern_word_pkg::ST_IDLE;
      word_q <= 13'h0;
      word_addr_q <= 6'h0;
      loop_start_q <= 6'h0;
      loop_cnt_q <= '0;
      loop_field_q <= '0;
      in_loop_q <= 1'b0;
      burst_q <= 1'b0;
      off_q <= 4'h0;
      step_q <= 4'h0;
      base_q <= 32'h0;
      addr_q <= 32'h0;
      bank_q <= '0;
      tbank_q <= '0;
      tcnt_q <= 16'h0;
      req_ack_q <= 1'b0;
      busy_q <= 1'b0;
      service_done_q <= 1'b0;
      internal_clock_phase_one_q <= 1'b0;
      internal_clock_phase_two_q <= 1'b0;
      general_line_four_q <= 1'b1;
      general_line_five_q <= 1'b1;
      transfer_ack_n_q <= 1'b1;
      bank_disable_timer_on_q <= 1'b0;
      bank_blocked_q <= 1'b0;
    end else begin
      st_q <= st_d;
      word_q <= word_d;
      word_addr_q <= waddr_d;
      loop_start_q <= loop_start_d;
      loop_cnt_q <= loop_cnt_d;
      loop_field_q <= loop_field_d;
      in_loop_q <= in_loop_d;
      burst_q <= burst_d;
      off_q <= off_d;
      step_q <= step_d;
      base_q <= base_d;
      addr_q <= addr_d;
      bank_q <= bank_d;
      tbank_q <= tbank_d;
      tcnt_q <= tcnt_d;
      req_ack_q <= ack_d;
      busy_q <= busy_d;
      service_done_q <= done_d;
      internal_clock_phase_one_q <= ph1_d;
      internal_clock_phase_two_q <= ph2_d;
      general_line_four_q <= l4_d;
      general_line_five_q <= l5_d;
      transfer_ack_n_q <= ta_n_d;
      bank_disable_timer_on_q <= ton_d;
      bank_blocked_q <= blk_d;
    end
  end
endmodule : memory_pattern_word_decoder

// File: test/pattern_store.sv
`timescale 1ns/100ps
module pattern_store (
  // Word fetch
  input wire logic [5:0] word_addr_q,
  output logic [12:0] word_upper
);
  logic [12:0] mem [64];
  // Answers at once: the machine samples the word in its phase-one cycle
  assign word_upper = mem[word_addr_q];
endmodule : pattern_store

// File: test/memory_pattern_word_decoder_properties.sv
`timescale 1ns/100ps
module memory_pattern_word_decoder_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched ports
  input wire logic req_ack_q,
  input wire logic busy_q,
  input wire logic service_done_q,
  input wire logic general_line_four_disable,
  input wire logic [12:0] word_upper,
  input wire logic internal_clock_phase_one_q,
  input wire logic internal_clock_phase_two_q,
  input wire logic general_line_four_q,
  input wire logic general_line_five_q,
  input wire logic transfer_ack_n_q,
  input wire logic bank_disable_timer_on_q,
  input wire logic bank_blocked_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ack_pulse_a: assert property (req_ack_q |-> busy_q && internal_clock_phase_one_q ##1 !req_ack_q)
    else $error("request ack is not a lone pulse at word start");
  phase_order_a: assert property (internal_clock_phase_one_q |=> internal_clock_phase_two_q)
    else $error("phase two did not follow phase one");
  ack_value_a: assert property (
    internal_clock_phase_one_q |=> transfer_ack_n_q == $past(word_upper[10]))
    else $error("transfer ack differs from word value");
  line_four_a: assert property (
    internal_clock_phase_one_q && !general_line_four_disable
      |=> general_line_four_q == $past(word_upper[0]))
    else $error("line four wrong after phase one");
  five_ph1_a: assert property (
    internal_clock_phase_one_q |=> general_line_five_q == $past(word_upper[2]))
    else $error("line five wrong after phase one");
  five_ph2_a: assert property (
    $fell(internal_clock_phase_two_q) |-> general_line_five_q == $past(word_upper[1]))
    else $error("line five wrong after phase two");
  done_last_a: assert property (service_done_q |-> !busy_q && $past(word_upper[12]))
    else $error("service ended without a final word");
  timer_word_a: assert property (bank_disable_timer_on_q |-> $past(word_upper[11]))
    else $error("disable timer started without its word bit");
  blocked_on_a: assert property (bank_disable_timer_on_q |-> bank_blocked_q)
    else $error("bank not blocked after disable timer start");
endmodule : memory_pattern_word_decoder_properties

// File: test/test_memory_pattern_word_decoder.sv
`timescale 1ns/100ps
module test_memory_pattern_word_decoder;
  logic mclk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, general_line_four_disable = 1'b0;
  logic [2:0] req_kind = 3'h0, req_bank = 3'h0, address_multiplex_scheme = 3'h0;
  logic [5:0] req_start = 6'h0;
  logic [31:0] req_addr = 32'h0, memory_address_holding_reg = 32'h0;
  logic [1:0] port_size = 2'h0;
  logic [3:0] read_loop_count = 4'h2, write_loop_count = 4'h3, timer_loop_count = 4'h4;
  logic wait_n = 1'b1, transfer_error_ack_n = 1'b1, reset_request = 1'b0;
  logic req_ack_q, busy_q, service_done_q, internal_clock_phase_one_q;
  logic internal_clock_phase_two_q, general_line_four_q, general_line_five_q;
  logic transfer_ack_n_q, bank_disable_timer_on_q, bank_blocked_q;
  logic [5:0] word_addr_q;
  logic [12:0] word_upper;
  logic [31:0] addr_q, ea;
  logic [5:0] seen [$];
  logic [31:0] adrs [$];
  int bad_count = 0, checks_done = 0, lat, dur, st, len, cnt;
  memory_pattern_word_decoder i_memory_pattern_word_decoder (.mclk, .rst_n, .req_valid,
    .req_kind, .req_start, .req_addr, .req_bank, .port_size, .req_ack_q, .busy_q,
    .service_done_q, .general_line_four_disable, .read_loop_count, .write_loop_count,
    .timer_loop_count, .address_multiplex_scheme, .memory_address_holding_reg,
    .word_addr_q, .word_upper, .wait_n, .transfer_error_ack_n, .reset_request,
    .internal_clock_phase_one_q, .internal_clock_phase_two_q, .general_line_four_q,
    .general_line_five_q, .addr_q, .transfer_ack_n_q, .bank_disable_timer_on_q,
    .bank_blocked_q);
  pattern_store i_pattern_store (.word_addr_q, .word_upper);
  always #25 mclk = ~mclk;
  task automatic tick();
    @(posedge mclk);
    #2;
  endtask : tick
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Random line, ack and address-source bits; control bits left to the caller
  function automatic logic [12:0] rw();
    return 13'($urandom) & 13'h0587;
  endfunction : rw
  // Address of a single-beat word: select code is bit 26 then bit 27
  function automatic logic [31:0] exp_addr(logic [12:0] w, logic [31:0] prev);
    case ({w[7], w[8]})
      2'h0: return req_addr;
      2'h2: return req_addr >> (pattern_word_pkg::MUX_SHIFT_BASE + address_multiplex_scheme);
      2'h3: return memory_address_holding_reg;
      default: return prev;
    endcase
  endfunction : exp_addr
  task automatic run(logic [2:0] kind, logic [5:0] s, logic [2:0] bank);
    seen.delete();
    adrs.delete();
    req_addr = $urandom & 32'hffff_fff0;
    memory_address_holding_reg = $urandom;
    address_multiplex_scheme = 3'($urandom_range(0, 7));
    port_size = 2'($urandom_range(0, 3));
    req_kind = kind;
    req_start = s;
    req_bank = bank;
    req_valid = 1'b1;
    lat = 0;
    do begin
      tick();
      lat++;
    end while (req_ack_q !== 1'b1 && lat < 60);
    req_valid = 1'b0;
    chk("ack", 32'h1, 32'(req_ack_q));
    dur = 0;
    while (service_done_q !== 1'b1 && dur < 400) begin
      if (internal_clock_phase_one_q === 1'b1) seen.push_back(word_addr_q);
      if (internal_clock_phase_two_q === 1'b1) adrs.push_back(addr_q);
      tick();
      dur++;
    end
    chk("done", 32'h1, 32'(service_done_q));
  endtask : run
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    conclude();
  end
  initial begin
    void'($urandom(84230));
    repeat (3) @(posedge mclk);
    chk("reset pins", 32'h7, 32'({general_line_four_q, general_line_five_q, transfer_ack_n_q}));
    #2 rst_n = 1'b1;
    for (int t = 0; t < 6; t++) begin
      st = $urandom_range(0, 40);
      len = $urandom_range(1, 6);
      for (int k = 0; k < len; k++) i_pattern_store.mem[st + k] = rw() | 13'(k == len - 1) << 12;
      ea = addr_q;
      run(3'($urandom_range(0, 1) * 2), 6'(st), 3'h0);
      chk("word count", 32'(len), 32'(seen.size()));
      for (int k = 0; k < seen.size(); k++) chk("word addr", 32'(st + k), 32'(seen[k]));
      for (int k = 0; k < len; k++) begin
        ea = exp_addr(i_pattern_store.mem[st + k], ea);
        chk("word address", ea, adrs[k]);
      end
    end
    i_pattern_store.mem[10] = rw();
    i_pattern_store.mem[11] = rw() | 13'h0020;
    i_pattern_store.mem[12] = rw() | 13'h0020;
    i_pattern_store.mem[13] = rw() | 13'h1000;
    read_loop_count = 4'($urandom_range(0, 5));
    timer_loop_count = 4'h0;
    for (int kind = 0; kind < 5; kind++) begin
      run(3'(kind), 6'h0a, 3'h1);
      cnt = kind < 2 ? read_loop_count : kind < 4 ? write_loop_count : timer_loop_count;
      chk("loop words", 32'(2 + 2 * (cnt == 0 ? 1 : cnt)), 32'(seen.size()));
    end
    // Case 0 bursts with increments, 1 is single (increment bit set but ignored), 2 burst without
    for (int c = 0; c < 3; c++) begin
      for (int k = 20; k < 22; k++) i_pattern_store.mem[k] = (rw() & 13'h1e7f) | 13'(c < 2) << 9;
      i_pattern_store.mem[22] = rw() | 13'h1180;
      run(c == 1 ? 3'h0 : 3'h1, 6'h14, 3'h2);
      for (int k = 0; k < 3; k++) begin
        ea = req_addr;
        if (c == 0) ea[3:0] = 4'((k < 2 ? k + 1 : 2) * (port_size == 0 ? 4 : port_size == 1 ? 2 : 1));
        if (k == 2) ea = memory_address_holding_reg;
        chk("address", ea, adrs[k]);
      end
    end
    i_pattern_store.mem[30] = rw() | 13'h0040;
    i_pattern_store.mem[31] = rw() | 13'h1000;
    i_pattern_store.mem[60] = rw();
    i_pattern_store.mem[61] = rw() | 13'h1000;
    for (int e = 0; e < 3; e++) begin
      transfer_error_ack_n = e != 1;
      reset_request = e == 2;
      repeat (6) tick();
      run(3'h0, 6'h1e, 3'h3);
      chk("after branch word", e == 0 ? 32'h1f : 32'h3c, 32'(seen[1]));
      chk("branch words", e == 0 ? 32'h2 : 32'h3, 32'(seen.size()));
      transfer_error_ack_n = 1'b1;
      reset_request = 1'b0;
      repeat (6) tick();
    end
    general_line_four_disable = 1'b1;
    wait_n = 1'b0;
    i_pattern_store.mem[40] = 13'h1001;
    repeat (6) tick();
    fork
      begin
        repeat (30) tick();
        chk("frozen", 32'h3, 32'({busy_q, internal_clock_phase_two_q}));
        wait_n = 1'b1;
      end
      run(3'h0, 6'h28, 3'h4);
    join
    chk("freeze span", 32'h1, 32'(dur > 25));
    general_line_four_disable = 1'b0;
    i_pattern_store.mem[50] = 13'h1800;
    run(3'h0, 6'h32, 3'h5);
    chk("timer start", 32'h3, 32'({bank_disable_timer_on_q, bank_blocked_q}));
    run(3'h0, 6'h32, 3'h5);
    chk("same bank held", 32'h1, 32'(lat > 1));
    run(3'h0, 6'h32, 3'h6);
    chk("other bank free", 32'h1, 32'(lat));
    conclude();
  end
endmodule : test_memory_pattern_word_decoder
bind memory_pattern_word_decoder memory_pattern_word_decoder_properties i_props (.mclk, .rst_n,
  .req_ack_q, .busy_q, .service_done_q, .general_line_four_disable, .word_upper,
  .internal_clock_phase_one_q, .internal_clock_phase_two_q, .general_line_four_q,
  .general_line_five_q, .transfer_ack_n_q, .bank_disable_timer_on_q, .bank_blocked_q);
